// ---- rtl/rsr_top.sv ----
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "rsr_regs.svh"

// Function
// R1 - pending unmasked interrupt ends standby at once
// R2 - stop release waits fixed 34 us
// R3 - resonator clock adds selected settle wait
// R4 - external reset pin held low 2 us
// R5 - any reset stops system and slow clocks
// R6 - pin-as-port low still resets before reread
// R7 - pin-as-port reset holds while pin low
// R8 - detector reset leaves the detector untouched
// R9 - watchdog reset also resets the watchdog
// R10 - cause flags read only as whole word
// R11 - power-on-clear clears cause flags to zero
module rsr_top #(
    parameter int NUM_IRQ = 8,
    parameter int SETTLE_LOG2_BASE = 10,
    parameter int TIMER_W = 18
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic reset_pin_n_i,
    input wire logic power_on_clear_i,
    input wire logic low_voltage_detector_i,
    input wire logic wdt_overflow_i,
    input wire logic option_ref_i,
    input wire logic stop_req_i,
    input wire logic [NUM_IRQ-1:0] irq_flag_i,
    input wire logic [NUM_IRQ-1:0] irq_mask_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [31:0] rdata_o,
    output logic sys_reset_o,
    output logic sys_clk_stop_o,
    output logic slow_osc_stop_o,
    output logic lvd_reset_o,
    output logic wdt_reset_o,
    output logic cpu_run_o
);
    // ****************************************************************
    // constants and checks
    // ****************************************************************
    localparam int STOP_CYC_I = `RSR_STOP_NS / `RSR_CLK_NS;
    localparam logic [TIMER_W-1:0] STOP_CYC = TIMER_W'(STOP_CYC_I);
    localparam int PIN_MIN_CYC = (`RSR_PIN_MIN_NS + `RSR_CLK_NS - 1) / `RSR_CLK_NS;
    localparam int HOLD_CYC = `RSR_WDT_HOLD;

    generate
        if (NUM_IRQ < 1 || SETTLE_LOG2_BASE < 1 ||
            SETTLE_LOG2_BASE + 7 >= TIMER_W || STOP_CYC_I >= (1 << TIMER_W))
        begin : g_chk
            $error("rsr_top: parameters out of range");
        end
    endgenerate

    // settle wait in cycles from the 3-bit select code
    function automatic logic [TIMER_W-1:0] settle_cycles(input logic [2:0] sel);
        settle_cycles = TIMER_W'(1) << (SETTLE_LOG2_BASE + int'(sel));
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0] pin_sync_reg;
    logic [1:0] poc_sync_reg;
    logic [1:0] lvd_sync_reg;

    // analogue and pin sources come from outside the clock domain
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_sync_reg <= 2'h3; // idle level of the pin, no false low after reset
            poc_sync_reg <= 2'h3;
            lvd_sync_reg <= 2'h0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[0], reset_pin_n_i};
            poc_sync_reg <= {poc_sync_reg[0], power_on_clear_i};
            lvd_sync_reg <= {lvd_sync_reg[0], low_voltage_detector_i};
        end
    end

    logic pin_low;
    logic poc_act;
    logic lvd_act;
    assign pin_low = !pin_sync_reg[1];
    assign poc_act = poc_sync_reg[1];
    assign lvd_act = lvd_sync_reg[1];

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] cause_reg;
    logic [2:0] settle_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] rdata_reg;
    rsr_pkg::rsr_state_type state_reg;
    rsr_pkg::rsr_state_type state_next;
    rsr_pkg::rsr_src_type src;
    logic xtal_mode;
    logic pin_port;

    assign xtal_mode = ctrl_reg[`RSR_CTRL_XTAL];
    assign pin_port = ctrl_reg[`RSR_CTRL_PINPORT];

    // config survives internal resets, power-on-clear returns it to default
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            settle_reg <= `RSR_SETTLE_RST;
            ctrl_reg <= `RSR_CTRL_RST;
        end
        else if (poc_act)
        begin
            settle_reg <= `RSR_SETTLE_RST;
            ctrl_reg <= `RSR_CTRL_RST;
        end
        else if (write_i && addr_i == `RSR_OFS_SETTLE)
            settle_reg <= wdata_i[2:0];
        else if (write_i && addr_i == `RSR_OFS_CTRL)
            ctrl_reg <= wdata_i[1:0];
    end

    // read data one cycle after the strobe; whole-word only, no side effects
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_reg <= 32'h0;
        else if (read_i)
        begin
            case (addr_i)
                `RSR_OFS_CAUSE: rdata_reg <= {24'h0, cause_reg}; // [R10]
                `RSR_OFS_SETTLE: rdata_reg <= {29'h0, settle_reg};
                `RSR_OFS_CTRL: rdata_reg <= {30'h0, ctrl_reg};
                `RSR_OFS_STATUS: rdata_reg <= {28'h0, sys_reset_o, 2'(state_reg), cpu_run_o};
                default: rdata_reg <= 32'h0;
            endcase
        end
        else
            rdata_reg <= 32'h0;
    end
    assign rdata_o = rdata_reg;

    // ****************************************************************
    // reset sources
    // ****************************************************************
    logic armed_reg;
    logic [3:0] hold_reg;

    // pin-as-port window opens at power-on-clear release, closes on reread
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            armed_reg <= 1'b1;
        else if (poc_act)
            armed_reg <= 1'b1; // [R6]
        else if (option_ref_i && !pin_low)
            armed_reg <= 1'b0;
    end

    // watchdog overflow is a pulse, stretched into a reset of fixed length
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            hold_reg <= 4'h0;
        else if (wdt_overflow_i)
            hold_reg <= 4'(HOLD_CYC);
        else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end

    // a port-mode pin resets only inside the window, then for as long as low
    assign src.pin = pin_low && (!pin_port || armed_reg); // [R6] [R7]
    assign src.power_on_clear = poc_act;
    assign src.lvd = lvd_act;
    assign src.wdt = (hold_reg != 4'h0);

    logic rst_any;
    assign rst_any = src.pin || src.power_on_clear || src.lvd || src.wdt;

    // cause flags: set wins over power-on-clear clear only for later sources
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cause_reg <= `RSR_CAUSE_RST;
        else if (src.power_on_clear)
            cause_reg <= `RSR_CAUSE_RST; // [R11]
        else
        begin
            if (wdt_overflow_i)
                cause_reg[`RSR_CAUSE_WDT] <= 1'b1;
            if (src.lvd)
                cause_reg[`RSR_CAUSE_LVD] <= 1'b1;
            if (src.pin)
                cause_reg[`RSR_CAUSE_PIN] <= 1'b1;
        end
    end

    // ****************************************************************
    // stop mode sequencer
    // ****************************************************************
    logic pending;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_done;
    logic tmr_busy;

    assign pending = |(irq_flag_i & ~irq_mask_i); // [R1]

    // pending request at entry goes straight into the release wait
    always_comb
    begin
        state_next = state_reg;
        tmr_load = 1'b0;
        tmr_val = STOP_CYC;
        case (state_reg)
            rsr_pkg::ST_RUN:
                if (stop_req_i)
                begin
                    state_next = rsr_pkg::ST_STOP_WAIT;
                    tmr_load = pending; // [R1]
                    if (!pending)
                        state_next = rsr_pkg::ST_STOP;
                end
            rsr_pkg::ST_STOP:
                if (pending)
                begin
                    state_next = rsr_pkg::ST_STOP_WAIT; // [R1]
                    tmr_load = 1'b1; // [R2]
                end
            rsr_pkg::ST_STOP_WAIT:
                if (tmr_done)
                begin
                    state_next = rsr_pkg::ST_RUN;
                    if (xtal_mode)
                    begin
                        state_next = rsr_pkg::ST_SETTLE; // [R3]
                        tmr_load = 1'b1;
                        tmr_val = settle_cycles(settle_reg);
                    end
                end
            rsr_pkg::ST_SETTLE:
                if (tmr_done)
                    state_next = rsr_pkg::ST_RUN;
            default:
                state_next = rsr_pkg::ST_RUN;
        endcase
    end

    // any reset aborts standby
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            state_reg <= rsr_pkg::ST_RUN;
        else if (rst_any)
            state_reg <= rsr_pkg::ST_RUN;
        else
            state_reg <= state_next;
    end

    rsr_wait_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(rst_any),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    // registered so downstream sees clean levels; reset_i forces all resets on
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sys_reset_o <= 1'b1;
            sys_clk_stop_o <= 1'b1;
            slow_osc_stop_o <= 1'b1;
            lvd_reset_o <= 1'b1;
            wdt_reset_o <= 1'b1;
            cpu_run_o <= 1'b0;
        end
        else
        begin
            sys_reset_o <= rst_any;
            sys_clk_stop_o <= rst_any || state_next != rsr_pkg::ST_RUN; // [R5]
            slow_osc_stop_o <= rst_any; // [R5]
            lvd_reset_o <= src.pin || src.power_on_clear || src.wdt; // [R8]
            wdt_reset_o <= rst_any; // [R9]
            cpu_run_o <= !rst_any && state_next == rsr_pkg::ST_RUN;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    // cycles spent in the release wait; too long for a delay range
    logic [TIMER_W-1:0] wait_cnt_reg;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            wait_cnt_reg <= '0;
        else if (state_reg == rsr_pkg::ST_STOP_WAIT && !rst_any)
            wait_cnt_reg <= wait_cnt_reg + TIMER_W'(1);
        else
            wait_cnt_reg <= '0;
    end

    sequence s_release;
        state_reg == rsr_pkg::ST_STOP && pending && !rst_any;
    endsequence

    sequence s_wait_full;
        (state_reg == rsr_pkg::ST_STOP_WAIT && !rst_any) [*8];
    endsequence

    a_pending_leaves_stop: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        s_release |=> state_reg == rsr_pkg::ST_STOP_WAIT)
        else $error("pending interrupt did not end stop");

    a_entry_with_pending: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        state_reg == rsr_pkg::ST_RUN && stop_req_i && pending && !rst_any
        |=> state_reg == rsr_pkg::ST_STOP_WAIT)
        else $error("stop entered despite pending interrupt");

    a_stop_wait_len: assert property (@(posedge clk_i) disable iff (reset_i || rst_any) // [R2]
        state_reg == rsr_pkg::ST_STOP_WAIT && state_next != rsr_pkg::ST_STOP_WAIT
        |-> wait_cnt_reg == STOP_CYC - TIMER_W'(1))
        else $error("stop interval length wrong");

    a_stop_wait_min: assert property (@(posedge clk_i) disable iff (reset_i || rst_any) // [R2]
        $rose(state_reg == rsr_pkg::ST_STOP_WAIT) |-> s_wait_full)
        else $error("stop interval ended early");

    a_settle_follows: assert property (@(posedge clk_i) disable iff (reset_i || rst_any) // [R3]
        state_reg == rsr_pkg::ST_STOP_WAIT && tmr_done && xtal_mode
        |=> state_reg == rsr_pkg::ST_SETTLE && tmr_busy)
        else $error("settle wait skipped");

    a_no_settle_rc: assert property (@(posedge clk_i) disable iff (reset_i || rst_any) // [R3]
        state_reg == rsr_pkg::ST_STOP_WAIT && tmr_done && !xtal_mode
        |=> state_reg == rsr_pkg::ST_RUN ##1 cpu_run_o)
        else $error("release without resonator not direct");

    a_clocks_stop_reset: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
        rst_any |=> sys_clk_stop_o && slow_osc_stop_o && !cpu_run_o)
        else $error("clocks run during reset");

    a_port_pin_holds: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
        pin_port && src.pin && pin_low |=> sys_reset_o)
        else $error("port-mode pin reset not held");

    a_lvd_self_spared: assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
        src.lvd && !src.pin && !src.power_on_clear && !src.wdt |=> sys_reset_o && !lvd_reset_o)
        else $error("detector reset by its own reset");

    a_wdt_self_reset: assert property (@(posedge clk_i) disable iff (reset_i) // [R9]
        wdt_overflow_i |-> ##2 wdt_reset_o [*8])
        else $error("watchdog reset too short");

    a_poc_clears_cause: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
        src.power_on_clear |=> cause_reg == 8'h00)
        else $error("cause flags not cleared by power-on-clear");

    a_pin_window_shut: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
        pin_port && !armed_reg && !src.power_on_clear |-> !src.pin)
        else $error("port-mode pin reset outside window");
endmodule // rsr_top

// ---- rtl/rsr_regs.svh ----
`ifndef RSR_REGS_SVH
`define RSR_REGS_SVH
// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define RSR_OFS_CAUSE 8'h00
`define RSR_OFS_SETTLE 8'h04
`define RSR_OFS_CTRL 8'h08
`define RSR_OFS_STATUS 8'h0c
// ****************************************************************
// field positions
// ****************************************************************
`define RSR_CAUSE_WDT 0
`define RSR_CAUSE_LVD 1
`define RSR_CAUSE_PIN 2
`define RSR_CTRL_XTAL 0
`define RSR_CTRL_PINPORT 1
`define RSR_SETTLE_W 3
// ****************************************************************
// reset values
// ****************************************************************
`define RSR_CAUSE_RST 8'h00
`define RSR_SETTLE_RST 3'h0
`define RSR_CTRL_RST 2'h0
// ****************************************************************
// timing
// ****************************************************************
`define RSR_CLK_NS 20
`define RSR_STOP_NS 34000
`define RSR_PIN_MIN_NS 2000
`define RSR_WDT_HOLD 8
`endif

// ---- rtl/rsr_pkg.sv ----
package rsr_pkg;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOP,
        ST_STOP_WAIT,
        ST_SETTLE
    } rsr_state_type;

    // one bit per reset source
    typedef struct packed {
        logic pin;
        logic power_on_clear;
        logic lvd;
        logic wdt;
    } rsr_src_type;
endpackage

// ---- rtl/rsr_wait_timer.sv ----
`timescale 1ns/1ps
// down-counter: load a count, done pulses on the last cycle
module rsr_wait_timer #(
    parameter int W = 18
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_reg;

    generate
        if (W < 11)
        begin : g_chk
            $error("rsr_wait_timer: W too small for the stop interval");
        end
    endgenerate

    // count down to zero; clear wins over load
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cnt_reg <= '0;
        else if (clear_i)
            cnt_reg <= '0;
        else if (load_i)
            cnt_reg <= load_val_i;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    assign busy_o = (cnt_reg != '0);
    // done must not look at load: the caller derives its load from done
    assign done_o = (cnt_reg == {{(W-1){1'b0}}, 1'b1}) && !clear_i;

    a_timer_done_one: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && !load_i |=> !busy_o)
        else $error("timer still busy after done");
endmodule // rsr_wait_timer

// ---- bench/rsr_partner.sv ----
`timescale 1ns/1ps
// ****************************************************************
// external reset driver and interrupt sources
// ****************************************************************
module rsr_partner #(
    parameter int NUM_IRQ = 8,
    parameter int PIN_MIN = 100
) (
    input wire logic clk_i,
    output logic reset_pin_n_o,
    output logic [NUM_IRQ-1:0] irq_flag_o,
    output logic [NUM_IRQ-1:0] irq_mask_o
);
    // idle: pin released high, no requests, all masked
    initial
    begin
        reset_pin_n_o = 1'b1;
        irq_flag_o = '0;
        irq_mask_o = '1;
    end

    // a shorter pulse is stretched, the device may miss it otherwise
    task automatic pin_low(input int n);
        int len;
        len = (n < PIN_MIN) ? PIN_MIN : n;
        @(posedge clk_i);
        reset_pin_n_o <= 1'b0;
        repeat (len) @(posedge clk_i);
        reset_pin_n_o <= 1'b1;
    endtask

    // request and mask flags change together, right after an edge
    task automatic set_irq(input logic [NUM_IRQ-1:0] f, input logic [NUM_IRQ-1:0] m);
        @(posedge clk_i);
        irq_flag_o <= f;
        irq_mask_o <= m;
    endtask
endmodule // rsr_partner

// ---- bench/rsr_top_tb.sv ----
`timescale 1ns/1ps
`include "rsr_regs.svh"
module rsr_top_tb;
    localparam int NUM_IRQ = 8;
    localparam int STOP_CYC = `RSR_STOP_NS / `RSR_CLK_NS;
    logic clk_i = 1'b0;
    logic reset_i, pin_n, power_on_clear, lvd, wdt_ovf, opt_ref, stop_req, write, read, rd_d;
    logic [NUM_IRQ-1:0] irq_flag, irq_mask;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic sys_reset, clk_stop, osc_stop, lvd_reset, wdt_reset, cpu_run;
    int num_errors = 0;
    int total_checks = 0;
    int n, n0;
    logic [31:0] exp_q[$];
    string name_q[$];

    rsr_top #(.NUM_IRQ(NUM_IRQ), .SETTLE_LOG2_BASE(1), .TIMER_W(18)) i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .reset_pin_n_i(pin_n),
        .power_on_clear_i(power_on_clear), .low_voltage_detector_i(lvd),
        .wdt_overflow_i(wdt_ovf), .option_ref_i(opt_ref), .stop_req_i(stop_req),
        .irq_flag_i(irq_flag), .irq_mask_i(irq_mask), .addr_i(addr),
        .wdata_i(wdata), .write_i(write), .read_i(read), .rdata_o(rdata),
        .sys_reset_o(sys_reset), .sys_clk_stop_o(clk_stop),
        .slow_osc_stop_o(osc_stop), .lvd_reset_o(lvd_reset),
        .wdt_reset_o(wdt_reset), .cpu_run_o(cpu_run)
    );

    rsr_partner #(.NUM_IRQ(NUM_IRQ), .PIN_MIN(`RSR_PIN_MIN_NS / `RSR_CLK_NS)) i_partner (
        .clk_i(clk_i), .reset_pin_n_o(pin_n), .irq_flag_o(irq_flag), .irq_mask_o(irq_mask)
    );

    // ****************************************************************
    // clock, compare and verdict
    // ****************************************************************
    always #10 clk_i = ~clk_i;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask

    task automatic results;
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge clk_i) rd_d <= read;
    always @(negedge clk_i)
    begin
        if (rd_d === 1'b1)
            check(name_q.pop_front(), rdata, exp_q.pop_front());
    end

    // ****************************************************************
    // drivers
    // ****************************************************************
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk_i);
        write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
        @(posedge clk_i);
        addr <= a;
        read <= 1'b1;
        exp_q.push_back(e);
        name_q.push_back(name);
        @(posedge clk_i);
        read <= 1'b0;
    endtask

    // one-cycle strobes: 0 stop request, 1 watchdog overflow, 2 option re-read
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0: stop_req <= 1'b1;
            1: wdt_ovf <= 1'b1;
            default: opt_ref <= 1'b1;
        endcase
        @(posedge clk_i);
        {stop_req, wdt_ovf, opt_ref} <= 3'h0;
    endtask

    // bounded so a design that never wakes still lets the run end
    task automatic wait_run(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
        while (cpu_run !== 1'b1 && cnt < 5000);
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        reset_i = 1'b1;
        {power_on_clear, lvd, wdt_ovf, opt_ref, stop_req, write, read} = 7'h00;
        addr = 8'h00;
        wdata = 32'h0;
        void'($urandom(32'h2d8eb077));
        cyc(4);
        reset_i <= 1'b0;
        cyc(10);
        rd(`RSR_OFS_CAUSE, 32'h0, "cause after power-up");
        rd(`RSR_OFS_CTRL, 32'h0, "ctrl reset");
        rd(8'h10, 32'h0, "unmapped read");
        rv = $urandom;
        wr(`RSR_OFS_SETTLE, rv);
        rd(`RSR_OFS_SETTLE, rv & 32'h7, "settle select");
        check("run after reset", {31'h0, cpu_run}, 32'h1);
        // masked requests must not end standby
        pulse(0);
        cyc(3);
        check("stopped", {30'h0, cpu_run, clk_stop}, 32'h1);
        rd(`RSR_OFS_STATUS, 32'h2, "status in stop");
        i_partner.set_irq(rv[15:8], 8'hff);
        cyc(50);
        check("masked wake", {31'h0, cpu_run}, 32'h0);
        i_partner.set_irq(rv[15:8] | 8'h01, 8'hfe);
        wait_run(n0);
        check("stop interval", {31'h0, n0 >= STOP_CYC && n0 <= STOP_CYC + 5}, 32'h1);
        // request already pending when standby is entered
        pulse(0);
        cyc(3);
        check("pending stop", {31'h0, cpu_run}, 32'h0);
        wait_run(n);
        check("pending wake", {31'h0, n + 3 >= STOP_CYC && n <= STOP_CYC + 5}, 32'h1);
        // resonator mode adds 2^(1+sel) cycles after the fixed interval
        for (int sel = 0; sel < 4; sel++)
        begin
            i_partner.set_irq(8'h00, 8'hff);
            wr(`RSR_OFS_SETTLE, sel);
            wr(`RSR_OFS_CTRL, 32'h1);
            pulse(0);
            cyc(5);
            i_partner.set_irq(8'h80, 8'h7f);
            wait_run(n);
            check("settle wait", n, n0 + (1 << (1 + sel)));
        end
        i_partner.set_irq(8'h00, 8'hff);
        wr(`RSR_OFS_CTRL, 32'h0);
        // external pin reset
        fork
            i_partner.pin_low(100);
            begin
                cyc(50);
                check("pin reset", {28'h0, sys_reset, clk_stop, osc_stop, cpu_run}, 32'he);
            end
        join
        cyc(10);
        check("pin released", {31'h0, sys_reset}, 32'h0);
        rd(`RSR_OFS_CAUSE, 32'h4, "cause pin");
        // detector reset spares the detector
        @(posedge clk_i) lvd <= 1'b1;
        cyc(10);
        check("lvd reset", {29'h0, sys_reset, osc_stop, lvd_reset}, 32'h6);
        @(posedge clk_i) lvd <= 1'b0;
        cyc(10);
        rd(`RSR_OFS_CAUSE, 32'h6, "cause lvd");
        // watchdog reset also resets the watchdog
        pulse(1);
        cyc(2);
        check("wdt reset", {30'h0, wdt_reset, lvd_reset}, 32'h3);
        cyc(20);
        check("wdt released", {31'h0, wdt_reset}, 32'h0);
        rd(`RSR_OFS_CAUSE, 32'h7, "cause wdt");
        // power-on-clear wipes the cause flags
        @(posedge clk_i) power_on_clear <= 1'b1;
        cyc(10);
        check("poc reset", {31'h0, sys_reset}, 32'h1);
        @(posedge clk_i) power_on_clear <= 1'b0;
        cyc(10);
        rd(`RSR_OFS_CAUSE, 32'h0, "cause poc");
        // pin as input-only port, window still open
        wr(`RSR_OFS_CTRL, 32'h2);
        fork
            i_partner.pin_low(300);
            begin
                cyc(50);
                check("port pin reset", {31'h0, sys_reset}, 32'h1);
                // an option re-read while the pin is low must not release it
                pulse(2);
                cyc(228);
                check("port pin hold", {31'h0, sys_reset}, 32'h1);
            end
        join
        cyc(10);
        check("port pin high", {31'h0, sys_reset}, 32'h0);
        // window closed by the option re-read
        wr(`RSR_OFS_CTRL, 32'h2);
        pulse(2);
        fork
            i_partner.pin_low(100);
            begin
                cyc(50);
                check("port pin ignored", {31'h0, sys_reset}, 32'h0);
            end
        join
        cyc(10);
        results();
    end

    // whole run is about 11000 cycles
    initial
    begin
        cyc(60000);
        num_errors++;
        results();
    end
endmodule // rsr_top_tb
